// ===== hdl/cpsm_status.v
/*
  can protocol status and high priority message status block with an
  ahb-lite register slave and a level interrupt.
  assumes the protocol engine supplies one-cycle event pulses on hclk,
  a bit-time strobe, and that can_rx comes from the pin (synchronised).
*/
// Notes on behaviour
// (RL1) after a brs data phase the next event goes to the data-phase code.
// (RL2) an error in a fixed stuff bit of the fd crc is reported as form error.
// (RL3) entering bus-off sets the init flag itself and halts bus activity.
// (RL4) software cannot shorten the bus-off recovery via the init flag.
// (RL5) after init clears, 129 idle sequences of 11 recessive bits are waited.
// (RL6) the end of recovery resets transmit and receive error counters.
// (RL7) each 11-recessive sequence in recovery writes bit0 error code.
// (RL8) the receive error counter counts those sequences during recovery.
// (RL9) delay comp value in bits 22:16 is measured delay plus offset.
// (RL10) priority status updates on every priority filter match.
// (RL11) bit 15 gives the filter list: 0 standard, 1 extended.
// (RL12) bits 14:8 hold the matching filter index.
// (RL13) bits 7:6 give the storage indicator.
// (RL14) bits 5:0 hold the buffer or fifo element index.
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_consts.vh"

module cpsm_status (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        can_rx,
  input  wire        bit_tick,
  input  wire        ev_valid,
  input  wire        ev_error,
  input  wire [2:0]  ev_code,
  input  wire        ev_fd_crc_stuff,
  input  wire        brs_data_phase,
  input  wire        go_bus_off,
  input  wire        error_warning_state,
  input  wire        error_passive_state,
  input  wire [1:0]  node_activity,
  input  wire        protocol_exception_flag,
  input  wire        fd_frame_received,
  input  wire        rate_switch_received,
  input  wire        error_state_indicator_received,
  input  wire [6:0]  tdc_measured,
  input  wire        tdc_update,
  input  wire        inc_tec,
  input  wire        inc_rec,
  input  wire        prio_match,
  input  wire        filter_list_select,
  input  wire [6:0]  matching_filter_index,
  input  wire [1:0]  storage_indicator,
  input  wire [5:0]  buffer_index,
  output wire        bus_halt,
  output wire        irq
);

  // =========================================================
  // ahb-lite slave
  reg        wr_pend_ff;
  reg        rd_pend_ff;
  reg [11:0] addr_ff;
  wire       take = hsel & hready & htrans[1];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 12'h000;
    end else begin
      wr_pend_ff <= take & hwrite;
      rd_pend_ff <= take & ~hwrite;
      if (take) begin
        addr_ff <= haddr[11:0];
      end
    end
  end

  wire wr_ctrl = wr_pend_ff & (addr_ff == `CPSM_OFF_CTRL);
  wire wr_mask = wr_pend_ff & (addr_ff == `CPSM_OFF_IRQ_MASK);
  // read-to-clear happens at the address phase so data shows old bits
  wire rd_stat = take & ~hwrite & (haddr[11:0] == `CPSM_OFF_IRQ_STAT);

  // =========================================================
  // can_rx synchroniser
  reg rx_s1_ff;
  reg rx_s2_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= can_rx;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // =========================================================
  // bus-off and recovery
  reg       init_ff;
  reg       bus_off_ff;
  reg [3:0] rec_bits_ff;
  reg [7:0] rec_ff;
  reg [7:0] tec_ff;
  reg [2:0] lec_ff;
  reg [2:0] data_phase_error_code_field_ff;
  reg       fd_pend_ff;
  reg [6:0] delay_comp_value_ff;
  reg [6:0] tdco_ff;

  wire enter_bo   = go_bus_off & ~bus_off_ff;
  wire recovering = bus_off_ff & ~init_ff;
  wire seq_done   = recovering & bit_tick & rx_s2_ff &
                    (rec_bits_ff == `CPSM_IDLE_BITS - 4'h1);
  wire recov_end  = seq_done & (rec_ff == `CPSM_IDLE_SEQS - 8'h01);

  assign bus_halt = bus_off_ff | init_ff; // [RL3]

  // =========================================================
  // init request flag
  // setting the flag again in recovery only pauses the idle count; the
  // sequences already seen are kept, so the wait is never cut short
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_ff <= 1'b0;
    end else if (enter_bo) begin
      init_ff <= 1'b1; // [RL3]
    end else if (wr_ctrl) begin
      init_ff <= hwdata[0]; // [RL4]
    end
  end

  // =========================================================
  // bus-off flag
  // only the full idle count ends bus-off; no register write touches it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_off_ff <= 1'b0;
    end else if (enter_bo) begin
      bus_off_ff <= 1'b1; // [RL3]
    end else if (recov_end) begin
      bus_off_ff <= 1'b0; // [RL5]
    end
  end

  // =========================================================
  // recessive bit run
  // a dominant bit restarts the run, so a stuck bus never completes one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_bits_ff <= 4'h0;
    end else if (enter_bo) begin
      rec_bits_ff <= 4'h0;
    end else if (recovering & bit_tick) begin
      if (!rx_s2_ff | seq_done) begin
        rec_bits_ff <= 4'h0;
      end else begin
        rec_bits_ff <= rec_bits_ff + 4'h1; // [RL5]
      end
    end
  end

  // =========================================================
  // error counters
  // outside bus-off the counters saturate instead of wrapping
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_ff <= 8'h00;
    end else if (enter_bo | recov_end) begin
      rec_ff <= 8'h00; // [RL6]
    end else if (seq_done) begin
      rec_ff <= rec_ff + 8'h01; // [RL8]
    end else if (~bus_off_ff & inc_rec & (rec_ff != 8'hFF)) begin
      rec_ff <= rec_ff + 8'h01;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tec_ff <= 8'h00;
    end else if (recov_end) begin
      tec_ff <= 8'h00; // [RL6]
    end else if (~bus_off_ff & inc_tec & (tec_ff != 8'hFF)) begin
      tec_ff <= tec_ff + 8'h01;
    end
  end

  // =========================================================
  // error codes
  wire [2:0] ev_cls  = ev_fd_crc_stuff ? `CPSM_EC_FORM : ev_code; // [RL2]
  wire [2:0] ev_val  = ev_error ? ev_cls : `CPSM_EC_NONE;
  wire       ev_any  = ev_valid | ev_error;
  wire       to_data = ev_any & (fd_pend_ff | brs_data_phase);

  // the recovery bit0 code wins over a protocol event in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lec_ff <= `CPSM_EC_NOCHANGE;
    end else if (seq_done) begin
      lec_ff <= `CPSM_EC_BIT0; // [RL7]
    end else if (ev_any & ~to_data) begin
      lec_ff <= ev_val;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_phase_error_code_field_ff <= `CPSM_EC_NOCHANGE;
    end else if (to_data & ~seq_done) begin
      data_phase_error_code_field_ff <= ev_val; // [RL1]
    end
  end

  // a rate switch marks the next event, whichever cycle it comes in
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fd_pend_ff <= 1'b0;
    end else if (ev_any) begin
      fd_pend_ff <= 1'b0;
    end else if (brs_data_phase) begin
      fd_pend_ff <= 1'b1; // [RL1]
    end
  end

  // =========================================================
  // delay compensation
  // the field is seven bits wide; a sum above 127 wraps, so software
  // must keep measured delay plus offset inside the field's range
  wire [7:0] tdc_sum = {1'b0, tdc_measured} + {1'b0, tdco_ff};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdco_ff <= 7'h00;
    end else if (wr_ctrl) begin
      tdco_ff <= hwdata[14:8];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_comp_value_ff <= 7'h00;
    end else if (tdc_update) begin
      delay_comp_value_ff <= tdc_sum[6:0]; // [RL9]
    end
  end

  // =========================================================
  // priority message status
  reg [15:0] priority_message_status_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      priority_message_status_ff <= `CPSM_PRIORITY_MESSAGE_STATUS_FLD_RST;
    end else if (prio_match) begin
      priority_message_status_ff <= {filter_list_select,      // [RL10] [RL11]
                  matching_filter_index,   // [RL12]
                  storage_indicator,       // [RL13]
                  buffer_index};           // [RL14]
    end
  end

  // =========================================================
  // interrupts: set wins over read-to-clear
  reg [`CPSM_IRQ_W-1:0] ist_ff;
  reg [`CPSM_IRQ_W-1:0] imask_ff;
  wire [`CPSM_IRQ_W-1:0] iset = {prio_match, recov_end, enter_bo};

  // an event in the cycle of the clearing read survives that read, so
  // software sees it on its next read instead of losing it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_ff <= 3'h0;
    end else begin
      ist_ff <= (rd_stat ? 3'h0 : ist_ff) | iset;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_ff <= 3'h0;
    end else if (wr_mask) begin
      imask_ff <= hwdata[`CPSM_IRQ_W-1:0];
    end
  end
  assign irq = |(ist_ff & imask_ff);

  // =========================================================
  // read data
  wire [31:0] pstat = {9'h000, delay_comp_value_ff, 1'b0, protocol_exception_flag,
                       fd_frame_received, rate_switch_received,
                       error_state_indicator_received, data_phase_error_code_field_ff,
                       bus_off_ff, error_warning_state,
                       error_passive_state, node_activity, lec_ff};
  reg [31:0] nxt_rdata;
  always @* begin
    case (haddr[11:0])
      `CPSM_OFF_PSTAT:    nxt_rdata = pstat;
      `CPSM_OFF_PRIORITY_MESSAGE_STATUS:     nxt_rdata = {16'h0000, priority_message_status_ff};
      `CPSM_OFF_CTRL:     nxt_rdata = {17'h00000, tdco_ff, 7'h00, init_ff};
      `CPSM_OFF_IRQ_STAT: nxt_rdata = {29'h0, ist_ff};
      `CPSM_OFF_IRQ_MASK: nxt_rdata = {29'h0, imask_ff};
      `CPSM_OFF_ERRCNT:   nxt_rdata = {16'h0000, rec_ff, tec_ff};
      default:            nxt_rdata = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

endmodule // cpsm_status
`default_nettype wire

// ===== hdl/cpsm_consts.vh
/*
  constants for the can protocol status and priority match block:
  register offsets, field positions, reset values and bit counts.
  assumes inclusion by bare name from the design file.
*/
`ifndef CPSM_CONSTS_VH
`define CPSM_CONSTS_VH

// ===========================================================
// register byte offsets
`define CPSM_OFF_PSTAT     12'h044
`define CPSM_OFF_PRIORITY_MESSAGE_STATUS      12'h094
`define CPSM_OFF_CTRL      12'h000
`define CPSM_OFF_IRQ_STAT  12'h010
`define CPSM_OFF_IRQ_MASK  12'h014
`define CPSM_OFF_ERRCNT    12'h040

// ===========================================================
// reset values
`define CPSM_PSTAT_RST     32'h00000707
`define CPSM_PRIORITY_MESSAGE_STATUS_RST      32'h00000000
`define CPSM_PRIORITY_MESSAGE_STATUS_FLD_RST  16'h0000

// ===========================================================
// error codes
`define CPSM_EC_NONE       3'h0
`define CPSM_EC_STUFF      3'h1
`define CPSM_EC_FORM       3'h2
`define CPSM_EC_BIT0       3'h5
`define CPSM_EC_NOCHANGE   3'h7

// ===========================================================
// bus-off recovery counts
`define CPSM_IDLE_BITS     4'hB
`define CPSM_IDLE_SEQS     8'h81

// ===========================================================
// interrupt status bit positions
`define CPSM_IRQ_BUSOFF    0
`define CPSM_IRQ_RECOV     1
`define CPSM_IRQ_PRIO      2
`define CPSM_IRQ_W         3

`endif

// ===== dv/cpsm_can_node.sv
/* neighbour nodes on an idle can bus: recessive level plus bit strobe.
   assumes hclk from the bench; disturb asks for one dominant bit. */
`timescale 1ns/1ps
`default_nettype none
module cpsm_can_node #(
  parameter int DIV = 4
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic disturb,
  output var  logic can_rx,
  output var  logic bit_tick
);
  logic [3:0] div_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 4'h0;
      bit_tick <= 1'b0;
      can_rx <= 1'b1;
    end else begin
      div_ff <= (div_ff == DIV - 1) ? 4'h0 : div_ff + 4'h1;
      bit_tick <= (div_ff == DIV - 1);
      // a dominant bit restarts the idle run of the receiver
      if (div_ff == DIV - 1)
        can_rx <= !disturb;
    end
  end
endmodule // cpsm_can_node
`default_nettype wire

// ===== dv/cpsm_status_chk.sv
/* port checker for cpsm_status.
   assumes the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module cpsm_status_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic        bit_tick,
  input wire logic        go_bus_off,
  input wire logic        prio_match,
  input wire logic        bus_halt,
  input wire logic        irq
);
  // ==========
  // helper counts
  logic        bo_ff;
  logic [11:0] tick_ff;
  logic [1:0]  since_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bo_ff <= 1'b0;
      tick_ff <= 12'h000;
      since_ff <= 2'h3;
    end else begin
      since_ff <= bit_tick ? 2'h0 : since_ff + {1'b0, since_ff != 2'h3};
      if (go_bus_off)
        bo_ff <= 1'b1;
      else if (!bus_halt)
        bo_ff <= 1'b0;
      if (go_bus_off)
        tick_ff <= 12'h000;
      else if (bo_ff && bit_tick && tick_ff != 12'hFFF)
        tick_ff <= tick_ff + 12'h001;
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_busoff_halts: assert property (go_bus_off |=> bus_halt)
    else $error("no halt");
  a_halt_holds: assert property (go_bus_off |=> bus_halt[*8])
    else $error("halt dropped");
  a_recov_long: assert property ($fell(bus_halt) && bo_ff |->
    tick_ff >= 12'h58B) else $error("recovery short");
  a_recov_tick: assert property ($fell(bus_halt) && bo_ff |->
    since_ff != 2'h3) else $error("recovery off tick");
  a_rdata_hold: assert property (!$past(hsel && hready && htrans[1]
    && !hwrite) |-> $stable(hrdata)) else $error("hrdata moved");
  a_reset_quiet: assert property ($rose(hresetn) |-> !bus_halt && !irq)
    else $error("busy after reset");
  c_bus_off: cover property (go_bus_off);
  c_recov: cover property ($fell(bus_halt) && bo_ff);
  c_prio: cover property (prio_match ##2 irq);
endmodule // cpsm_status_chk
bind cpsm_status cpsm_status_chk u_chk (.hclk, .hresetn, .hreadyout,
  .hresp, .hrdata, .hsel, .hready, .hwrite, .htrans, .bit_tick,
  .go_bus_off, .prio_match, .bus_halt, .irq);
`default_nettype wire

// ===== dv/tb_top.sv
/* self-checking bench for cpsm_status: ahb-lite master and event drivers.
   assumes cpsm_can_node and the bound checker are compiled before. */
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_consts.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  fails++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, disturb;
  logic [31:0] haddr, hwdata, hrdata, q, q2;
  logic [1:0]  htrans, node_activity, storage_indicator;
  logic [2:0]  hsize, ev_code;
  logic [6:0]  tdc_measured, matching_filter_index, off;
  logic [5:0]  buffer_index;
  logic        can_rx, bit_tick, ev_valid, ev_error, ev_fd_crc_stuff;
  logic        brs_data_phase, go_bus_off, error_warning_state;
  logic        error_passive_state, protocol_exception_flag;
  logic        fd_frame_received, rate_switch_received;
  logic        error_state_indicator_received, tdc_update, inc_tec;
  logic        inc_rec, prio_match, filter_list_select, bus_halt, irq;
  logic        counting;
  int          fails, comparisons, ticks;
  wire         hready;
  assign hready = hreadyout;
  cpsm_status u_cpsm_status (.*);
  cpsm_can_node #(.DIV(4)) u_cpsm_can_node (.hclk, .hresetn, .disturb,
    .can_rx, .bit_tick);
  function automatic logic [31:0] f_priority_message_status(logic f, logic [6:0] x,
    logic [1:0] s, logic [5:0] b);
    return {16'h0000, f, x, s, b};
  endfunction
  function automatic logic [31:0] f_tdc(logic [6:0] m, o);
    return {9'h000, m + o, 16'h0000};
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rd(input string n, input logic [31:0] a, m, e);
    ahb(1'b0, a, 32'h0);
    `CHK(n, e & m, q & m)
  endtask
  task automatic irq_is(input logic e);
    @(negedge hclk);
    `CHK("irq", e, irq)
    @(posedge hclk);
  endtask
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge hclk) if (counting && bit_tick) ticks++;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, disturb, ev_valid, ev_error, counting} = '0;
    {ev_fd_crc_stuff, brs_data_phase, go_bus_off, tdc_update} = '0;
    {inc_tec, inc_rec, prio_match, error_warning_state} = '0;
    {error_passive_state, node_activity, protocol_exception_flag} = '0;
    {fd_frame_received, rate_switch_received, haddr, hwdata} = '0;
    {error_state_indicator_received, htrans, ev_code, tdc_measured} = '0;
    {filter_list_select, matching_filter_index, storage_indicator} = '0;
    {buffer_index, fails, comparisons, ticks} = '0;
    hsize = 3'h2;
    void'($urandom(36));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("pstat", `CPSM_OFF_PSTAT, '1, `CPSM_PSTAT_RST);
    rd("priority_message_status", `CPSM_OFF_PRIORITY_MESSAGE_STATUS, '1, `CPSM_PRIORITY_MESSAGE_STATUS_RST);
    rd("unmapped", 32'h200, '1, 32'h0);
    // a valid frame after a rate switch lands in the data-phase field
    brs_data_phase <= 1'b1;
    @(posedge hclk) brs_data_phase <= 1'b0;
    ev_valid <= 1'b1;
    @(posedge hclk) ev_valid <= 1'b0;
    rd("data_phase_error_code_field", `CPSM_OFF_PSTAT, 32'h707, 32'h007);
    {ev_error, ev_fd_crc_stuff, ev_code} <= {2'h3, `CPSM_EC_STUFF};
    @(posedge hclk) {ev_error, ev_fd_crc_stuff} <= 2'h0;
    rd("lec", `CPSM_OFF_PSTAT, 32'h707, 32'h002);
    for (int i = 0; i < 4; i++) begin
      off = (i == 0) ? 7'h3F : 7'($urandom_range(63));
      tdc_measured <= (i == 0) ? 7'h40 : 7'($urandom_range(63));
      ahb(1'b1, `CPSM_OFF_CTRL, {17'h0, off, 8'h00});
      tdc_update <= 1'b1;
      @(posedge hclk) tdc_update <= 1'b0;
      rd("tdc", `CPSM_OFF_PSTAT, 32'h7F0000, f_tdc(tdc_measured, off));
    end
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, `CPSM_OFF_IRQ_MASK, (i < 2) ? 32'h4 : 32'h0);
      {filter_list_select, storage_indicator} <= {i[0], i[1:0]};
      {matching_filter_index, buffer_index} <= 13'($urandom);
      prio_match <= 1'b1;
      @(posedge hclk) prio_match <= 1'b0;
      rd("priority_message_status", `CPSM_OFF_PRIORITY_MESSAGE_STATUS, '1, f_priority_message_status(i[0], matching_filter_index,
        i[1:0], buffer_index));
      irq_is(i < 2);
      rd("irq_stat", `CPSM_OFF_IRQ_STAT, 32'h4, 32'h4);
      irq_is(1'b0);
    end
    ahb(1'b1, `CPSM_OFF_IRQ_MASK, 32'h2);
    {inc_tec, inc_rec} <= 2'h3;
    repeat (2) @(posedge hclk);
    {inc_tec, inc_rec, go_bus_off} <= 3'h1;
    @(posedge hclk) go_bus_off <= 1'b0;
    rd("bus_off", `CPSM_OFF_PSTAT, 32'h80, 32'h80);
    `CHK("halt", 1'b1, bus_halt)
    ahb(1'b1, `CPSM_OFF_CTRL, 32'h0);
    counting <= 1'b1;
    repeat (300) @(posedge hclk);
    rd("bit0", `CPSM_OFF_PSTAT, 32'h7, `CPSM_EC_BIT0);
    ahb(1'b0, `CPSM_OFF_ERRCNT, 32'h0);
    q2 = q;
    disturb <= 1'b1;
    repeat (4) @(posedge hclk);
    disturb <= 1'b0;
    ahb(1'b1, `CPSM_OFF_CTRL, 32'h1);
    ahb(1'b1, `CPSM_OFF_CTRL, 32'h0);
    repeat (120) @(posedge hclk);
    ahb(1'b0, `CPSM_OFF_ERRCNT, 32'h0);
    `CHK("rec_runs", 1'b1, q[15:8] > q2[15:8])
    while (bus_halt !== 1'b0) @(posedge hclk);
    counting <= 1'b0;
    `CHK("idle_runs", 1'b1, ticks >= 129 * 11)
    rd("errcnt", `CPSM_OFF_ERRCNT, '1, 32'h0);
    irq_is(1'b1);
    rd("recov", `CPSM_OFF_IRQ_STAT, 32'h2, 32'h2);
    irq_is(1'b0);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
